// *** switch_core.sv ***
`timescale 1ns/1ps
`include "core_map.svh"
module switch_core
  import core_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // stack configuration and trained widths
  input wire logic [2:0] split,
  input wire logic [4:0][3:0] ing_w,
  input wire logic [4:0][3:0] egr_w,
  // ingress words per stack, time shared when split
  input wire logic [2:0] in_valid,
  input wire logic [2:0] in_sop,
  input wire logic [2:0] in_eop,
  input wire logic [2:0][65:0] in_data,
  input wire logic [2:0][1:0] in_class,
  input wire logic [2:0][9:0] in_len,
  input wire logic [2:0] in_ins_cpl,
  output logic [2:0] in_ready,
  // dequeue requests from the picker per port
  input wire logic [4:0] deq_valid,
  input wire logic [4:0][1:0] deq_class,
  input wire logic [4:0][2:0] deq_dest,
  input wire logic [4:0][9:0] deq_len,
  input wire logic [4:0] deq_ins_cpl,
  output logic [4:0] deq_ready,
  // replay buffer acknowledge per port
  input wire logic [4:0] orb_ack,
  input wire logic [4:0][9:0] orb_ack_len,
  // status
  output logic ubus_busy,
  output logic dbus_busy,
  output logic dec_full,
  output logic [2:0] parity_err,
  output logic [2:0] egress_odd_slot,
  output logic [15:0] arrival_ts,
  // advertised credits
  output logic [7:0] hdr_credits,
  output logic [11:0] pc_data_credits,
  output logic [11:0] np_data_credits
);
  // ****************************************
  // helpers
  // ****************************************
  // internal index 0..4 stands for ports 0,2,3,4,5
  function automatic logic [2:0] port_of(input int s, input logic odd);
    logic [2:0] base;
    base = (s == 0) ? 3'h0 : 3'(2 * s - 1);
    return base + {2'b00, odd};
  endfunction

  function automatic int stack_of(input int idx);
    return (idx + 1) / 2;
  endfunction

  function automatic logic [13:0] byte_lim(input logic [1:0] c);
    unique case (c)
      CLS_NP: return {1'b0, `NP_BYTES};
      CLS_INS: return {1'b0, `INS_BYTES};
      default: return {1'b0, `PC_BYTES};
    endcase
  endfunction

  function automatic logic [11:0] words_of(input logic [9:0] len);
    return 12'(({2'b00, len} + 12'h001) >> 1);
  endfunction

  core_state_type st_r;
  core_state_type st_nxt;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic odd;
    logic live;
    logic admit;
    logic ct;
    logic head;
    logic room;
    logic bus;
    logic peer;
    logic ugrant;
    logic dgrant;
    logic [2:0] pi;
    logic [2:0] d;
    logic [1:0] c;
    logic [1:0] ec;
    logic [12:0] b;
    logic [13:0] olim;
    logic [5:0] otl;
    odd = 1'b0;
    live = 1'b0;
    admit = 1'b0;
    ct = 1'b0;
    head = 1'b0;
    room = 1'b0;
    bus = 1'b0;
    peer = 1'b0;
    ugrant = 1'b0;
    dgrant = 1'b0;
    pi = 3'h0;
    d = 3'h0;
    c = 2'b00;
    ec = 2'b00;
    b = 13'h0000;
    olim = 14'h0000;
    otl = 6'h00;
    st_nxt = st_r;
    in_ready = '0;
    deq_ready = '0;
    st_nxt.phase = ~st_r.phase;
    st_nxt.ts = st_r.ts + 16'h0001;
    st_nxt.par_err = '0;
    if (st_r.ubus_cnt != 12'h000) begin
      st_nxt.ubus_cnt = st_r.ubus_cnt - 12'h001;
    end
    if (st_r.dbus_cnt != 12'h000) begin
      st_nxt.dbus_cnt = st_r.dbus_cnt - 12'h001;
    end
    for (int p = 0; p < `NPORT; p++) begin
      if (st_r.lat[p] != 4'h0) begin
        st_nxt.lat[p] = st_r.lat[p] - 4'h1;
      end
    end
    // ingress demux; an unsplit stack owns every slot (x8)
    for (int s = 0; s < `NSTACK; s++) begin
      odd = split[s] & st_r.phase;
      pi = port_of(s, odd);
      // the odd slot of stack 0 has no port behind it
      live = in_valid[s] && !(s == 0 && odd);
      c = in_class[s];
      b = {1'b0, in_len[s], 2'b00};
      admit = (st_r.tlps[pi][c] < ((c == CLS_INS) ? `INS_TLP_MAX
              : `TLP_MAX)) &&
              ({1'b0, st_r.bytes[pi][c]} + {1'b0, b} <= byte_lim(c));
      if (c == CLS_INS) begin
        admit = admit && !(in_ins_cpl[s] ? st_r.ins_c[pi]
                : st_r.ins_p[pi]);
      end
      in_ready[s] = !live || !in_sop[s] || admit;
      if (live && in_ready[s]) begin
        if (in_sop[s]) begin
          st_nxt.tlps[pi][c] = st_r.tlps[pi][c] + 6'h01;
          st_nxt.bytes[pi][c] = st_r.bytes[pi][c] + b;
          st_nxt.open[pi] = 1'b1;
          st_nxt.cut[pi] = 1'b0;
          st_nxt.open_cls[pi] = c;
          st_nxt.lat[pi] = (ing_w[pi] == `WIDTH_X1) ? 4'(`LAT_X1X1_CYC)
                           : 4'(`LAT_X4X1_CYC);
          if (c == CLS_INS && in_ins_cpl[s]) begin
            st_nxt.ins_c[pi] = 1'b1;
          end else if (c == CLS_INS) begin
            st_nxt.ins_p[pi] = 1'b1;
          end
        end
        if (in_eop[s]) begin
          ec = in_sop[s] ? c : st_r.open_cls[pi];
          st_nxt.open[pi] = 1'b0;
          if (!st_nxt.cut[pi]) begin
            st_nxt.done[pi][ec] = st_r.done[pi][ec] + 6'h01;
          end
        end
        // even parity: each parity bit equals the xor of its dword
        if (in_data[s][64] != ^in_data[s][31:0] ||
            in_data[s][65] != ^in_data[s][63:32]) begin
          st_nxt.par_err[s] = 1'b1;
        end
      end
    end
    // decoupler claims the down bus ahead of the upstream port
    unique case (st_r.dec)
      DEC_IDLE: begin
      end
      DEC_FILL: begin
        d = st_r.dec_dest;
        b = {1'b0, st_r.dec_len, 2'b00};
        olim = {1'b0, split[stack_of(int'(d))] ? `ORB_HALF_BYTES
                : `ORB_BYTES};
        otl = split[stack_of(int'(d))] ? `ORB_HALF_TLPS : `ORB_TLPS;
        if (st_r.dec_wait != 3'h0) begin
          st_nxt.dec_wait = st_r.dec_wait - 3'h1;
        end else if (st_r.dbus_cnt == 12'h000 &&
                     {1'b0, st_r.orb_bytes[d]} + {1'b0, b} <= olim &&
                     st_r.orb_tlps[d] < otl) begin
          dgrant = 1'b1;
          st_nxt.dec = DEC_DRAIN;
          st_nxt.dbus_cnt = words_of(st_r.dec_len);
          st_nxt.orb_bytes[d] = st_r.orb_bytes[d] + b;
          st_nxt.orb_tlps[d] = st_r.orb_tlps[d] + 6'h01;
        end else begin
          // waiting on the down bus still holds it for the decoupler
          dgrant = 1'b1;
        end
      end
      DEC_DRAIN: begin
        if (st_r.dbus_cnt == 12'h000) begin
          st_nxt.dec = DEC_IDLE;
        end
      end
      default: begin
        st_nxt.dec = DEC_IDLE;
      end
    endcase
    // dequeue; lowest port wins a shared bus, the picker should avoid it
    for (int i = 0; i < `NPORT; i++) begin
      c = deq_class[i];
      d = deq_dest[i];
      b = {1'b0, deq_len[i], 2'b00};
      peer = (i != 0) && (d != 3'h0);
      ct = (d < 3'(`NPORT)) && (ing_w[i] >= egr_w[d]);
      // store and forward needs a complete tlp at the head
      head = (st_r.done[i][c] != 6'h00) || (ct && st_r.open[i] &&
             !st_r.cut[i] && st_r.open_cls[i] == c &&
             st_r.lat[i] == 4'h0);
      head = head && (st_r.tlps[i][c] != 6'h00);
      olim = {1'b0, split[stack_of(int'(d))] ? `ORB_HALF_BYTES
              : `ORB_BYTES};
      otl = split[stack_of(int'(d))] ? `ORB_HALF_TLPS : `ORB_TLPS;
      if (d >= 3'(`NPORT) || (i == 0 && d == 3'h0)) begin
        room = 1'b0;
      end else if (peer) begin
        room = (st_r.dec == DEC_IDLE) && (b <= `DEC_BYTES);
      end else begin
        room = ({1'b0, st_r.orb_bytes[d]} + {1'b0, b} <= olim) &&
               (st_r.orb_tlps[d] < otl);
      end
      // up bus for downstream sources, down bus for port 0
      bus = (i == 0) ? (st_r.dbus_cnt == 12'h000 && !dgrant)
            : (st_r.ubus_cnt == 12'h000 && !ugrant);
      if (deq_valid[i] && head && room && bus) begin
        deq_ready[i] = 1'b1;
        st_nxt.tlps[i][c] = st_nxt.tlps[i][c] - 6'h01;
        // bytes are freed at launch, trading accuracy for area
        st_nxt.bytes[i][c] = st_nxt.bytes[i][c] - b;
        if (st_r.done[i][c] != 6'h00) begin
          st_nxt.done[i][c] = st_nxt.done[i][c] - 6'h01;
        end else begin
          st_nxt.done[i][c] = st_r.done[i][c];
          st_nxt.cut[i] = 1'b1;
        end
        if (c == CLS_INS && deq_ins_cpl[i]) begin
          st_nxt.ins_c[i] = 1'b0;
        end else if (c == CLS_INS) begin
          st_nxt.ins_p[i] = 1'b0;
        end
        // whole tlp at one word a cycle, x8 rate
        if (i == 0) begin
          dgrant = 1'b1;
          st_nxt.dbus_cnt = words_of(deq_len[i]);
        end else begin
          ugrant = 1'b1;
          st_nxt.ubus_cnt = words_of(deq_len[i]);
        end
        if (peer) begin
          st_nxt.dec = DEC_FILL;
          st_nxt.dec_dest = d;
          st_nxt.dec_len = deq_len[i];
          st_nxt.dec_wait = `DEC_CT_CYC;
        end else begin
          st_nxt.orb_bytes[d] = st_nxt.orb_bytes[d] + b;
          st_nxt.orb_tlps[d] = st_nxt.orb_tlps[d] + 6'h01;
        end
      end
    end
    // acknowledged tlps leave the replay buffer
    for (int p = 0; p < `NPORT; p++) begin
      b = {1'b0, orb_ack_len[p], 2'b00};
      if (orb_ack[p] && st_nxt.orb_tlps[p] != 6'h00) begin
        st_nxt.orb_tlps[p] = st_nxt.orb_tlps[p] - 6'h01;
        st_nxt.orb_bytes[p] = (st_nxt.orb_bytes[p] > b) ?
                              st_nxt.orb_bytes[p] - b : 13'h0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
      st_r.ts <= `TS_RESET;
      st_r.dec <= DEC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign ubus_busy = st_r.ubus_cnt != 12'h000;
  assign dbus_busy = st_r.dbus_cnt != 12'h000;
  assign dec_full = st_r.dec != DEC_IDLE;
  assign parity_err = st_r.par_err;
  assign egress_odd_slot = split & {3{st_r.phase}};
  assign arrival_ts = st_r.ts;
  assign hdr_credits = `HDR_CREDITS;
  assign pc_data_credits = `PC_DATA_CREDITS;
  assign np_data_credits = `NP_DATA_CREDITS;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_phase_toggle: assert property (
    !$past(rst) |-> st_r.phase != $past(st_r.phase))
    else $error("slot phase did not alternate");
  chk_np_bytes: assert property (
    st_r.bytes[1][CLS_NP] <= `NP_BYTES)
    else $error("non-posted queue over byte limit");
  chk_ins_count: assert property (
    st_r.tlps[1][CLS_INS] <= `INS_TLP_MAX)
    else $error("insertion buffer over two tlps");
  chk_dec_single: assert property (
    dec_full |-> !(deq_ready[1] && deq_dest[1] != 3'h0))
    else $error("second tlp sent to full decoupler");
  chk_orb_cap: assert property (
    st_r.orb_bytes[2] <= `ORB_BYTES && st_r.orb_tlps[2] <= `ORB_TLPS)
    else $error("replay buffer over limit");
  chk_par_flag: assert property (
    in_valid[1] && in_ready[1] && in_data[1][64] != ^in_data[1][31:0]
    |=> parity_err[1])
    else $error("parity mismatch not flagged");
  chk_ct_latency: assert property (
    deq_ready[1] && st_r.done[1][deq_class[1]] == 6'h00
    |-> st_r.lat[1] == 4'h0)
    else $error("cut-through before least latency");
  chk_ts_run: assert property (
    !$past(rst) |-> arrival_ts == $past(arrival_ts) + 16'h0001)
    else $error("timestamp not free-running");
  chk_ubus_claim: assert property (
    deq_ready[1] && deq_dest[1] == 3'h0 && deq_len[1] > 10'h002
    |=> ubus_busy [*2])
    else $error("up bus not held for transfer");
  cov_both_buses: cover property (ubus_busy && dbus_busy);
  cov_peer_drain: cover property (
    st_r.dec == DEC_FILL ##[1:20] st_r.dec == DEC_DRAIN);
  cov_cut_through: cover property (
    deq_ready[0] && st_r.done[0][deq_class[0]] == 6'h00);
  cov_split_ingress: cover property (split[2] && in_valid[2] && st_r.phase);
endmodule

// *** core_map.svh ***
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH
// ****************************************
// port, stack and class counts
// ****************************************
`define NPORT 5
`define NSTACK 3
`define NCLASS 4
// ****************************************
// ingress queue limits
// ****************************************
`define TLP_MAX 6'h20
`define INS_TLP_MAX 6'h02
`define PC_BYTES 13'h1000
`define NP_BYTES 13'h0300
`define INS_BYTES 13'h0030
// ****************************************
// output and replay buffer, decoupler
// ****************************************
`define ORB_BYTES 13'h1000
`define ORB_HALF_BYTES 13'h0800
`define ORB_TLPS 6'h20
`define ORB_HALF_TLPS 6'h10
`define DEC_BYTES 13'h0840
`define DEC_CT_CYC 3'h1
// ****************************************
// advertised flow control credits
// ****************************************
`define HDR_CREDITS 8'h20
`define PC_DATA_CREDITS 12'h040
`define NP_DATA_CREDITS 12'h020
// ****************************************
// timing
// ****************************************
`define CLK_NS 50
`define LAT_X4X1_NS 204
`define LAT_X1X1_NS 272
`define LAT_X4X1_CYC ((`LAT_X4X1_NS + `CLK_NS - 1) / `CLK_NS)
`define LAT_X1X1_CYC ((`LAT_X1X1_NS + `CLK_NS - 1) / `CLK_NS)
`define WIDTH_X1 4'h1
`define TS_RESET 16'h0000
`endif

// *** core_pkg.sv ***
package core_pkg;
  typedef enum logic [1:0] {
    CLS_P = 2'b00,
    CLS_NP = 2'b01,
    CLS_CPL = 2'b10,
    CLS_INS = 2'b11
  } tlp_class_type;

  typedef enum logic [1:0] {
    DEC_IDLE = 2'b00,
    DEC_FILL = 2'b01,
    DEC_DRAIN = 2'b10
  } dec_state_type;

  typedef struct packed {
    logic phase;
    logic [15:0] ts;
    logic [4:0][3:0][5:0] tlps;
    logic [4:0][3:0][12:0] bytes;
    logic [4:0][3:0][5:0] done;
    logic [4:0] open;
    logic [4:0] cut;
    logic [4:0][1:0] open_cls;
    logic [4:0][3:0] lat;
    logic [4:0] ins_p;
    logic [4:0] ins_c;
    logic [4:0][12:0] orb_bytes;
    logic [4:0][5:0] orb_tlps;
    logic [11:0] ubus_cnt;
    logic [11:0] dbus_cnt;
    dec_state_type dec;
    logic [2:0] dec_dest;
    logic [9:0] dec_len;
    logic [2:0] dec_wait;
    logic [2:0] par_err;
  } core_state_type;
endpackage

// *** stack_model.sv ***
`timescale 1ns/1ps
// ****************************************
// far side stacks: ingress words, acks
// ****************************************
module stack_model (
  // clock
  input wire logic mclk,
  // ingress toward the core
  output logic [2:0] in_valid,
  output logic [2:0] in_sop,
  output logic [2:0] in_eop,
  output logic [2:0][65:0] in_data,
  output logic [2:0][1:0] in_class,
  output logic [2:0][9:0] in_len,
  output logic [2:0] in_ins_cpl,
  input wire logic [2:0] in_ready,
  // egress acknowledge
  output logic [4:0] orb_ack,
  output logic [4:0][9:0] orb_ack_len
);
  initial begin
    in_valid = 3'h0;
    in_sop = 3'h0;
    in_eop = 3'h0;
    in_data = 198'h0;
    in_class = 6'h00;
    in_len = 30'h0;
    in_ins_cpl = 3'h0;
    orb_ack = 5'h00;
    orb_ack_len = 50'h0;
  end
  // entered at a rising edge, returns at the next rising edge, whether or not the word was taken
  task automatic word(input int s, input logic sop, input logic eop,
    input logic [1:0] cls, input logic [9:0] len, input logic cpl,
    input logic bad, output logic took);
    logic [63:0] d;
    d = {54'h0, len} ^ 64'hc3a5_0f0f_1234_8765;
    in_valid[s] <= 1'b1;
    in_sop[s] <= sop;
    in_eop[s] <= eop;
    in_data[s] <= {^d[63:32], (^d[31:0]) ^ bad, d};
    in_class[s] <= cls;
    in_len[s] <= len;
    in_ins_cpl[s] <= cpl;
    @(negedge mclk);
    took = in_ready[s];
    @(posedge mclk);
  endtask
  task automatic idle(input int s);
    in_valid[s] <= 1'b0;
    // released lines flip so a stale word never looks held
    in_data[s] <= ~in_data[s];
    @(posedge mclk);
  endtask
  task automatic ack(input int p, input logic [9:0] len);
    orb_ack[p] <= 1'b1;
    orb_ack_len[p] <= len;
    @(posedge mclk);
    orb_ack[p] <= 1'b0;
    orb_ack_len[p] <= ~len;
    @(posedge mclk);
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module tb
  import core_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] split, in_valid, in_sop, in_eop, in_ins_cpl, in_ready;
  logic [4:0][3:0] ing_w, egr_w;
  logic [2:0][65:0] in_data;
  logic [2:0][1:0] in_class;
  logic [2:0][9:0] in_len;
  logic [4:0] deq_valid, deq_ready, deq_ins_cpl, orb_ack;
  logic [4:0][1:0] deq_class;
  logic [4:0][2:0] deq_dest;
  logic [4:0][9:0] deq_len, orb_ack_len;
  logic ubus_busy, dbus_busy, dec_full;
  logic [2:0] parity_err, egress_odd_slot;
  logic [15:0] arrival_ts;
  logic [7:0] hdr_credits;
  logic [11:0] pc_data_credits, np_data_credits;
  int bad_count = 0;
  int compares = 0;

  always #25 mclk = ~mclk;

  switch_core u_dut (.mclk(mclk), .rst(rst), .split(split),
    .ing_w(ing_w), .egr_w(egr_w), .in_valid(in_valid), .in_sop(in_sop),
    .in_eop(in_eop), .in_data(in_data), .in_class(in_class),
    .in_len(in_len), .in_ins_cpl(in_ins_cpl), .in_ready(in_ready),
    .deq_valid(deq_valid), .deq_class(deq_class), .deq_dest(deq_dest),
    .deq_len(deq_len), .deq_ins_cpl(deq_ins_cpl), .deq_ready(deq_ready),
    .orb_ack(orb_ack), .orb_ack_len(orb_ack_len), .ubus_busy(ubus_busy),
    .dbus_busy(dbus_busy), .dec_full(dec_full), .parity_err(parity_err),
    .egress_odd_slot(egress_odd_slot), .arrival_ts(arrival_ts),
    .hdr_credits(hdr_credits), .pc_data_credits(pc_data_credits),
    .np_data_credits(np_data_credits));

  stack_model m (.mclk(mclk), .in_valid(in_valid), .in_sop(in_sop),
    .in_eop(in_eop), .in_data(in_data), .in_class(in_class),
    .in_len(in_len), .in_ins_cpl(in_ins_cpl), .in_ready(in_ready),
    .orb_ack(orb_ack), .orb_ack_len(orb_ack_len));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // n is the grant cycle, or lim when none came
  task automatic deq(input int p, input logic [1:0] cls,
    input logic [2:0] dst, input logic [9:0] len, input int lim,
    output int n);
    deq_valid[p] <= 1'b1;
    deq_class[p] <= cls;
    deq_dest[p] <= dst;
    deq_len[p] <= len;
    n = lim;
    for (int i = 0; i < lim && n == lim; i++) begin
      @(negedge mclk);
      if (deq_ready[p] === 1'b1) n = i;
      @(posedge mclk);
    end
    deq_valid[p] <= 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [15:0] a;
    @(negedge mclk);
    a = arrival_ts;
    chk({13'h0, ubus_busy, dbus_busy, dec_full}, 16'h0000);
    chk({8'h00, hdr_credits}, 16'h0020);
    chk({4'h0, pc_data_credits}, 16'h0040);
    chk({4'h0, np_data_credits}, 16'h0020);
    repeat (10) @(negedge mclk);
    chk(arrival_ts - a, 16'h000a);
    @(posedge mclk);
    $display("test reset done");
  endtask
  task automatic t_route();
    logic t;
    int n;
    int u;
    int d;
    m.word(0, 1'b1, 1'b1, CLS_P, 10'h008, 1'b0, 1'b0, t);
    m.idle(0);
    m.word(1, 1'b1, 1'b1, CLS_P, 10'h008, 1'b0, 1'b0, t);
    m.idle(1);
    deq(0, CLS_P, 3'h0, 10'h008, 6, n);
    chk(n[15:0], 16'h0006);
    @(posedge mclk);
    deq_dest[0] <= 3'h1;
    deq_len[1] <= 10'h008;
    deq_dest[1] <= 3'h0;
    deq_valid <= 5'h03;
    @(negedge mclk);
    chk({11'h0, deq_ready}, 16'h0003);
    @(posedge mclk);
    deq_valid <= 5'h00;
    u = 0;
    d = 0;
    repeat (8) begin
      @(negedge mclk);
      u += ubus_busy;
      d += dbus_busy;
    end
    chk(u[15:0], 16'h0004);
    chk(d[15:0], 16'h0004);
    @(posedge mclk);
    m.ack(0, 10'h008);
    $display("test route done");
  endtask
  task automatic t_peer();
    logic t;
    int n;
    int f;
    int k;
    m.word(1, 1'b1, 1'b1, CLS_P, 10'h008, 1'b0, 1'b0, t);
    m.idle(1);
    deq(1, CLS_P, 3'h3, 10'h008, 4, n);
    chk(n[15:0], 16'h0000);
    f = 0;
    k = 99;
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk);
      f += dec_full;
      if (dbus_busy === 1'b1 && k == 99) k = i;
    end
    chk({14'h0, f != 0, k >= 1 && k <= 5}, 16'h0003);
    repeat (4) @(negedge mclk);
    chk({15'h0, dec_full}, 16'h0000);
    @(posedge mclk);
    $display("test peer done");
  endtask
  task automatic t_limits();
    logic t;
    logic [9:0] cl [3] = '{10'h3e8, 10'h018, 10'h001};
    for (int i = 0; i < 4; i++) begin
      m.word(2, 1'b1, 1'b1, CLS_NP, 10'h040, 1'b0, 1'b0, t);
      m.idle(2);
      chk({15'h0, t}, {15'h0, i < 3});
    end
    for (int i = 0; i < 33; i++) begin
      m.word(2, 1'b1, 1'b1, CLS_P, 10'h001, 1'b0, 1'b0, t);
      m.idle(2);
      chk({15'h0, t}, {15'h0, i < 32});
    end
    for (int i = 0; i < 3; i++) begin
      m.word(2, 1'b1, 1'b1, CLS_CPL, cl[i], 1'b0, 1'b0, t);
      m.idle(2);
      chk({15'h0, t}, {15'h0, i < 2});
    end
    $display("test limits done");
  endtask
  task automatic t_ins();
    logic t;
    logic [9:0] ln [3] = '{10'h004, 10'h004, 10'h008};
    int n;
    for (int i = 0; i < 3; i++) begin
      m.word(1, 1'b1, 1'b1, CLS_INS, ln[i], i == 2, 1'b0, t);
      m.idle(1);
      chk({15'h0, t}, {15'h0, i != 1});
    end
    // launching the completion frees its slot for a new one
    deq_ins_cpl[1] <= 1'b1;
    deq(1, CLS_INS, 3'h0, 10'h008, 4, n);
    chk(n[15:0], 16'h0000);
    deq_ins_cpl[1] <= 1'b0;
    m.word(1, 1'b1, 1'b1, CLS_INS, 10'h004, 1'b1, 1'b0, t);
    m.idle(1);
    chk({15'h0, t}, 16'h0001);
    $display("test insertion done");
  endtask
  task automatic t_parity();
    logic t;
    m.word(1, 1'b1, 1'b1, CLS_P, 10'h001, 1'b0, 1'b1, t);
    fork
      m.idle(1);
      begin
        @(negedge mclk);
        chk({13'h0, parity_err}, 16'h0002);
      end
    join
    @(negedge mclk);
    chk({13'h0, parity_err}, 16'h0000);
    @(posedge mclk);
    $display("test parity done");
  endtask
  task automatic t_cut();
    logic t;
    int n;
    ing_w[1] <= 4'h4;
    egr_w[0] <= 4'h1;
    @(posedge mclk);
    m.word(1, 1'b1, 1'b0, CLS_CPL, 10'h010, 1'b0, 1'b0, t);
    m.idle(1);
    deq(1, CLS_CPL, 3'h0, 10'h010, 12, n);
    chk({15'h0, n >= 2 && n <= 6}, 16'h0001);
    m.word(1, 1'b0, 1'b1, CLS_CPL, 10'h010, 1'b0, 1'b0, t);
    m.idle(1);
    // narrower ingress holds the tlp until its last word
    ing_w[1] <= 4'h1;
    egr_w[0] <= 4'h4;
    @(posedge mclk);
    m.word(1, 1'b1, 1'b0, CLS_NP, 10'h004, 1'b0, 1'b0, t);
    m.idle(1);
    deq(1, CLS_NP, 3'h0, 10'h004, 12, n);
    chk(n[15:0], 16'h000c);
    m.word(1, 1'b0, 1'b1, CLS_NP, 10'h004, 1'b0, 1'b0, t);
    m.idle(1);
    deq(1, CLS_NP, 3'h0, 10'h004, 6, n);
    chk({15'h0, n < 6}, 16'h0001);
    $display("test cut done");
  endtask
  task automatic t_tdm();
    logic a;
    logic t;
    int n;
    split <= 3'h4;
    @(posedge mclk);
    @(negedge mclk);
    a = egress_odd_slot[2];
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk);
      chk({14'h0, egress_odd_slot[2:1]}, {14'h0, ~a, 1'b0});
      a = egress_odd_slot[2];
    end
    // launch so the word is taken in an odd slot of stack 2
    @(posedge mclk);
    if (a) @(posedge mclk);
    m.word(2, 1'b1, 1'b1, CLS_P, 10'h001, 1'b0, 1'b0, t);
    m.idle(2);
    deq(4, CLS_P, 3'h0, 10'h001, 4, n);
    chk(n[15:0], 16'h0000);
    $display("test tdm done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    split = 3'h0;
    ing_w = {5{4'h4}};
    egr_w = {5{4'h4}};
    deq_valid = 5'h00;
    deq_class = 10'h000;
    deq_dest = 15'h0000;
    deq_len = 50'h0;
    deq_ins_cpl = 5'h00;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_route();
    t_peer();
    t_limits();
    t_ins();
    t_parity();
    t_cut();
    t_tdm();
    finish_test();
  end
  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end
endmodule
